// ==== logic/phymii_core.sv ====
/*
 * media independent interface pin logic of a 10/100 transceiver, with registers on AXI4-Lite.
 * assumes line coding sits on the line_* ports in the ref_clk domain and a MAC on the pins.
 */
// How it works
// [RULE_01] transmit clock runs continuously, fast in 100 mode, slow in 10 mode.
// [RULE_02] transmit clock pin floats while isolated or in transmit high impedance mode.
// [RULE_03] transmit nibble captured at transmit clock rise only while enable is high.
// [RULE_04] the MAC raises enable only while presenting valid nibbles.
// [RULE_05] transmit error with enable sends an error code group instead of data.
// [RULE_06] in bypass mode transmit error becomes code group bit four.
// [RULE_07] outside repeater mode carrier sense follows transmit or receive activity.
// [RULE_08] in repeater mode carrier sense follows receive activity only.
// [RULE_09] collision pin shows medium collisions, plus the quality test in 10 mode.
// [RULE_10] receive clock runs continuously, fast in 100 mode, slow in 10 mode.
// [RULE_11] with gating set in 100 mode, receive clock stays low without receive data.
// [RULE_12] in 100 mode data valid covers preamble through the last data nibble.
// [RULE_13] in 10 mode data valid rises at the frame delimiter, not the preamble.
// [RULE_14] receive error shows frame errors, or code group bit four in bypass.
// [RULE_15] isolation floats receive data, valid, error, clock, carrier and collision.
// [RULE_16] reset pin low resets the whole block.
// [RULE_17] power-on and the self-clearing soft reset bit also reset the block.
// [RULE_18] interrupt pin floats when idle, else driven at the selected polarity.
// [RULE_19] software picks interrupt sources in the interrupt control register.
// [RULE_20] register accesses are timed by the management side clock.
// [RULE_21] repeater bit enables repeater mode, forbids full duplex, disables quality test.
// [RULE_22] interrupt asserts when any enabled status bit of eight is set.
// [RULE_23] transmit error is ignored in 10 mode outside bypass.
`timescale 1ns/1ps
`default_nettype none
module phymii_core
	import phymii_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// mii transmit pins
	output logic tx_clk_o,
	output logic tx_clk_oe,
	input wire logic tx_en,
	input wire logic [3:0] txd,
	input wire logic tx_er,
	// mii receive pins
	output logic rx_clk_o,
	output logic rx_clk_oe,
	output phymii_rx_t rx_o,
	output logic rx_oe,
	output logic crs_o,
	output logic col_o,
	output logic crs_col_oe,
	// interrupt pin
	output logic interrupt_output,
	output logic interrupt_output_oe,
	// line transmit side
	output phymii_cg_t line_tx,
	output logic line_tx_valid,
	// line receive side
	input wire logic line_rx_valid,
	input wire logic [4:0] line_rx_code,
	input wire logic line_rx_sfd,
	input wire logic line_rx_err,
	output logic line_rx_ready,
	input wire logic line_rx_active,
	input wire logic line_collision,
	input wire logic line_sqe,
	input wire logic line_link_change
);
	// reset sequencing
	logic [3:0] por_cnt;
	wire core_rst_n = rst_n && (por_cnt == 4'h0);

	// registers
	logic [15:0] control;
	logic [15:0] vendor;
	logic [15:0] int_ctrl;
	logic [1:0] mii_mode;

	// bus state
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// decoded modes
	wire speed100 = control[CTL_SPEED100];
	wire isolate = control[CTL_ISOLATE];
	wire repeater = vendor[VND_REPEATER];
	wire int_pol = vendor[VND_INT_POL];
	wire receive_clock_gating_bit = vendor[VND_RXCLK_GATE];
	wire transmit_high_impedance_mode = mii_mode[MODE_TRANSMIT_HIGH_IMPEDANCE_MODE];
	wire bypass = mii_mode[MODE_BYPASS];
	wire [3:0] half = speed100 ? HALF_100 : HALF_10;

	// pin synchronisers
	logic [5:0] tx_pins;
	wire s_tx_en = tx_pins[5];
	wire s_tx_er = tx_pins[4];
	wire [3:0] s_txd = tx_pins[3:0];

	phymii_sync #(.W(6)) u_tx_sync (
		.clk(ref_clk),
		.rst_n(core_rst_n),
		.ce(ce),
		.d({tx_en, tx_er, txd}),
		.q(tx_pins)
	);

	// clock generators
	logic tx_rise;
	logic rx_fall;
	logic rx_run;
	wire rx_gated = receive_clock_gating_bit && speed100 && !line_rx_active;

	phymii_clkdiv u_tx_div (
		.clk(ref_clk),
		.rst_n(core_rst_n),
		.ce(ce),
		.run(1'b1), // see [RULE_01]
		.half_cycles(half),
		.clk_o(tx_clk_o),
		.rise(tx_rise),
		.fall()
	);

	assign rx_run = !rx_gated; // see [RULE_11]

	phymii_clkdiv u_rx_div (
		.clk(ref_clk),
		.rst_n(core_rst_n),
		.ce(ce),
		.run(rx_run), // see [RULE_10]
		.half_cycles(half),
		.clk_o(rx_clk_o),
		.rise(),
		.fall(rx_fall)
	);

	assign tx_clk_oe = !isolate && !transmit_high_impedance_mode; // see [RULE_02]
	assign rx_clk_oe = !isolate; // see [RULE_15]
	assign rx_oe = !isolate; // see [RULE_15]
	assign crs_col_oe = !isolate; // see [RULE_15]

	// transmit capture
	wire tx_err_req = s_tx_er && s_tx_en && speed100; // see [RULE_05] [RULE_23]
	wire [4:0] tx_code = bypass ? {s_tx_er, s_txd} : (tx_err_req ? ERR_CODE : {1'b0, s_txd}); // see [RULE_06]
	wire tx_take = tx_rise && s_tx_en; // see [RULE_03]
	logic tx_act_q;

	always_ff @(posedge ref_clk) begin
		if (!core_rst_n) begin
			line_tx <= '0;
			line_tx_valid <= 1'b0;
			tx_act_q <= 1'b0;
		end else if (ce) begin
			line_tx_valid <= tx_take;
			if (tx_take) begin
				line_tx <= '{err: tx_err_req && !bypass, code: tx_code};
			end
			if (tx_rise) begin
				tx_act_q <= s_tx_en;
			end
		end
	end

	// carrier sense and collision
	wire sqe_on = line_sqe && !speed100 && !repeater; // see [RULE_21]
	wire next_crs = repeater ? line_rx_active : (line_rx_active || s_tx_en); // see [RULE_07] [RULE_08]
	wire next_col = line_collision || sqe_on; // see [RULE_09]

	always_ff @(posedge ref_clk) begin
		if (!core_rst_n) begin
			crs_o <= 1'b0;
			col_o <= 1'b0;
		end else if (ce) begin
			crs_o <= next_crs;
			col_o <= next_col;
		end
	end

	// receive drive on receive clock fall
	logic sfd_seen;
	wire rx_dv_now = speed100 || sfd_seen || line_rx_sfd; // see [RULE_12] [RULE_13]
	wire next_rx_er = bypass ? line_rx_code[4] : line_rx_err; // see [RULE_14]
	assign line_rx_ready = rx_fall;

	always_ff @(posedge ref_clk) begin
		if (!core_rst_n) begin
			rx_o <= '0;
			sfd_seen <= 1'b0;
		end else if (ce && rx_fall) begin
			if (line_rx_valid) begin
				rx_o <= '{er: next_rx_er && (rx_dv_now || bypass), dv: rx_dv_now,
					d: line_rx_code[3:0]};
				sfd_seen <= sfd_seen || line_rx_sfd;
			end else begin
				rx_o <= '0;
				sfd_seen <= 1'b0;
			end
		end else if (ce && rx_gated) begin
			rx_o <= '0;
			sfd_seen <= 1'b0;
		end
	end

	// interrupt events
	logic dv_q;
	logic er_q;
	logic col_q;
	logic txe_q;
	// bit 7 link, 6 dv fall, 5 tx end, 4 col rise, 3 tx error, 2 tx start, 1 er rise, 0 dv rise
	wire [7:0] events = {line_link_change, !rx_o.dv && dv_q, !tx_act_q && txe_q,
		col_o && !col_q, line_tx_valid && line_tx.err, tx_act_q && !txe_q,
		rx_o.er && !er_q, rx_o.dv && !dv_q};

	always_ff @(posedge ref_clk) begin
		if (!core_rst_n) begin
			dv_q <= 1'b0;
			er_q <= 1'b0;
			col_q <= 1'b0;
			txe_q <= 1'b0;
		end else if (ce) begin
			dv_q <= rx_o.dv;
			er_q <= rx_o.er;
			col_q <= col_o;
			txe_q <= tx_act_q;
		end
	end

	wire int_pending = |(int_ctrl[7:0] & int_ctrl[15:8]); // see [RULE_22]
	assign interrupt_output = int_pol; // see [RULE_18]
	assign interrupt_output_oe = int_pending; // see [RULE_18]

	// bus handshake, timed by ref_clk
	wire do_write = aw_full && w_full && !s_axi_bvalid; // see [RULE_20]
	assign s_axi_awready = ce && !aw_full && !s_axi_bvalid;
	assign s_axi_wready = ce && !w_full && !s_axi_bvalid;
	assign s_axi_arready = ce && !s_axi_rvalid;
	wire rd_take = s_axi_arvalid && s_axi_arready;

	wire wr_ctl = do_write && (aw_addr == ADDR_CONTROL);
	wire wr_vnd = do_write && (aw_addr == ADDR_VENDOR);
	wire wr_int = do_write && (aw_addr == ADDR_INT_CTRL);
	wire wr_mode = do_write && (aw_addr == ADDR_MII_MODE);
	wire wr_hit = wr_ctl || wr_vnd || wr_int || wr_mode || (aw_addr == ADDR_STATUS);
	wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [15:0] wval = w_data[15:0];
	wire rd_int = rd_take && (s_axi_araddr == ADDR_INT_CTRL);

	wire [15:0] rd_ctl = {por_cnt != 4'h0, control[14:9], control[CTL_DUPLEX] && !repeater,
		control[7:0]};
	wire [15:0] rd_status = {11'h000, crs_o, col_o, rx_o.dv, tx_act_q, rx_clk_o};
	wire rd_hit = (s_axi_araddr == ADDR_CONTROL) || (s_axi_araddr == ADDR_VENDOR) ||
		(s_axi_araddr == ADDR_INT_CTRL) || (s_axi_araddr == ADDR_MII_MODE) ||
		(s_axi_araddr == ADDR_STATUS);
	wire [15:0] rd_val = (s_axi_araddr == ADDR_CONTROL) ? rd_ctl :
		(s_axi_araddr == ADDR_VENDOR) ? vendor :
		(s_axi_araddr == ADDR_INT_CTRL) ? int_ctrl :
		(s_axi_araddr == ADDR_MII_MODE) ? {14'h0000, mii_mode} :
		(s_axi_araddr == ADDR_STATUS) ? rd_status : 16'h0000;

	// power-on and soft reset stretch
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			por_cnt <= POR_CYCLES; // see [RULE_16] [RULE_17]
		end else if (ce) begin
			if (wr_ctl && w_strb[1] && wval[CTL_SOFT_RESET]) begin
				por_cnt <= POR_CYCLES; // see [RULE_17]
			end else if (por_cnt != 4'h0) begin
				por_cnt <= por_cnt - 4'h1;
			end
		end
	end

	// bus channel state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {16'h0000, rd_val};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// register file, reset by every reset source
	wire [7:0] clr_mask = rd_int ? 8'hFF : 8'h00;
	wire [7:0] next_int_status = (int_ctrl[7:0] & ~clr_mask) | events; // see [RULE_22]
	wire [7:0] next_int_en = (wr_int && w_strb[1]) ? wval[15:8] : int_ctrl[15:8]; // see [RULE_19]

	always_ff @(posedge ref_clk) begin
		if (!core_rst_n) begin
			control <= CONTROL_RST; // see [RULE_16]
			vendor <= VENDOR_RST;
			int_ctrl <= INT_CTRL_RST;
			mii_mode <= MODE_RST;
		end else if (ce) begin
			if (wr_ctl) begin
				control <= ((control & ~wmask) | (wval & wmask)) & ~(16'h1 << CTL_SOFT_RESET);
			end
			if (wr_vnd) begin
				vendor <= (vendor & ~wmask) | (wval & wmask); // see [RULE_21]
			end
			if (wr_mode && w_strb[0]) begin
				mii_mode <= wval[1:0];
			end
			int_ctrl <= {next_int_en, next_int_status};
		end
	end
endmodule : phymii_core
`default_nettype wire

// ==== logic/phymii_pkg.sv ====
/*
 * shared constants and carriers for the transceiver media independent interface block.
 * assumes a 20 MHz reference clock and register access over a 32-bit AXI4-Lite bus.
 */
package phymii_pkg;
	// clock and timing
	localparam int REF_CLK_NS = 50;
	localparam int TXCLK_PERIOD_100_NS = 40;
	localparam int TXCLK_PERIOD_10_NS = 400;
	localparam int HALF_100_RAW = (TXCLK_PERIOD_100_NS / 2 + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int HALF_10_RAW = (TXCLK_PERIOD_10_NS / 2 + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam logic [3:0] HALF_100 = (HALF_100_RAW < 1) ? 4'h1 : 4'(HALF_100_RAW);
	localparam logic [3:0] HALF_10 = (HALF_10_RAW < 1) ? 4'h1 : 4'(HALF_10_RAW);
	localparam logic [3:0] POR_CYCLES = 4'h4;

	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_VENDOR = 8'h40;
	localparam logic [7:0] ADDR_INT_CTRL = 8'h44;
	localparam logic [7:0] ADDR_MII_MODE = 8'h4C;
	localparam logic [7:0] ADDR_STATUS = 8'h50;

	// control register fields
	localparam int CTL_SOFT_RESET = 15;
	localparam int CTL_SPEED100 = 13;
	localparam int CTL_ISOLATE = 10;
	localparam int CTL_DUPLEX = 8;
	// vendor register fields
	localparam int VND_REPEATER = 15;
	localparam int VND_INT_POL = 14;
	localparam int VND_RXCLK_GATE = 0;
	// mode register fields
	localparam int MODE_TRANSMIT_HIGH_IMPEDANCE_MODE = 0;
	localparam int MODE_BYPASS = 1;

	// reset values
	localparam logic [15:0] CONTROL_RST = 16'h2100;
	localparam logic [15:0] VENDOR_RST = 16'h0000;
	localparam logic [15:0] INT_CTRL_RST = 16'h0000;
	localparam logic [1:0] MODE_RST = 2'h0;

	// error code group sent for a transmit error request
	localparam logic [4:0] ERR_CODE = 5'h04;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic err;
		logic [4:0] code;
	} phymii_cg_t;

	typedef struct packed {
		logic er;
		logic dv;
		logic [3:0] d;
	} phymii_rx_t;
endpackage : phymii_pkg

// ==== logic/phymii_sync.sv ====
/*
 * two flip-flop synchroniser for pin inputs.
 * assumes inputs come from outside the ref_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module phymii_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : phymii_sync
`default_nettype wire

// ==== logic/phymii_clkdiv.sv ====
/*
 * divider that builds a link clock from ref_clk, with edge pulses.
 * assumes half_cycles is at least one and stable while run is high.
 */
`timescale 1ns/1ps
`default_nettype none
module phymii_clkdiv (
	// clock
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// control
	input wire logic run,
	input wire logic [3:0] half_cycles,
	// clock out
	output logic clk_o,
	output logic rise,
	output logic fall
);
	logic [3:0] cnt;
	wire last = (cnt + 4'h1 >= half_cycles);

	always_ff @(posedge clk) begin
		if (!rst_n || (ce && !run)) begin
			cnt <= 4'h0;
			clk_o <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else if (ce) begin
			cnt <= last ? 4'h0 : cnt + 4'h1;
			rise <= last && !clk_o;
			fall <= last && clk_o;
			if (last) begin
				clk_o <= !clk_o;
			end
		end
	end
endmodule : phymii_clkdiv
`default_nettype wire

// ==== tb/phymii_core_monitor.sv ====
/*
 * concurrent checks on the pin side of phymii_core.
 * assumes it is bound to the core and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module phymii_core_monitor
	import phymii_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// transmit pins
	input wire logic tx_clk_o,
	input wire logic tx_clk_oe,
	input wire logic tx_en,
	// receive pins
	input wire logic rx_clk_o,
	input wire logic rx_clk_oe,
	input wire phymii_rx_t rx_o,
	input wire logic rx_oe,
	input wire logic crs_o,
	input wire logic col_o,
	input wire logic crs_col_oe,
	// line side
	input wire logic line_tx_valid,
	input wire logic line_rx_valid,
	input wire logic line_rx_active,
	input wire logic line_collision
);
	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_iso_all_float: assert property (rx_oe == crs_col_oe && rx_oe == rx_clk_oe)
		else $error("receive side enables disagree");
	a_iso_tx_float: assert property (!rx_oe |-> !tx_clk_oe)
		else $error("transmit clock driven while isolated");
	a_tx_clk_runs: assert property (tx_clk_oe |-> ##[1:10] $changed(tx_clk_o))
		else $error("transmit clock stopped");
	a_rx_clk_runs: assert property (line_rx_active |-> ##[1:10] $changed(rx_clk_o))
		else $error("receive clock stopped during activity");
	a_dv_cause: assert property ($rose(rx_o.dv) |-> $past(line_rx_valid))
		else $error("data valid rose without a line nibble");
	a_crs_on_rx: assert property (line_rx_active [*6] |=> crs_o)
		else $error("carrier sense low during receive activity");
	a_col_follows: assert property (line_collision [*6] |=> col_o)
		else $error("collision not shown");
	a_tx_one_pulse: assert property (line_tx_valid |=> !line_tx_valid)
		else $error("nibble capture pulse too long");
	a_tx_idle_quiet: assert property (!tx_en [*5] |=> !line_tx_valid)
		else $error("nibble captured without enable");
endmodule : phymii_core_monitor

bind phymii_core phymii_core_monitor i_phymii_core_monitor (.ref_clk, .rst_n, .tx_clk_o,
	.tx_clk_oe, .tx_en, .rx_clk_o, .rx_clk_oe, .rx_o, .rx_oe, .crs_o, .col_o, .crs_col_oe,
	.line_tx_valid, .line_rx_valid, .line_rx_active, .line_collision);
`default_nettype wire

// ==== tb/phymii_mac_model.sv ====
/*
 * behavioural MAC transmit side driving the transmit pins.
 * assumes tx_clk is the transmit clock level seen at the MAC pins.
 */
`timescale 1ns/1ps
`default_nettype none
module phymii_mac_model (
	// control
	input wire logic tx_clk,
	input wire logic go,
	input wire logic er,
	input wire logic [3:0] nib,
	// pins
	output logic tx_en,
	output logic tx_er,
	output logic [3:0] txd
);
	initial begin
		tx_en = 1'b0;
		tx_er = 1'b0;
		txd = 4'h0;
	end
	// launch on the falling edge; idle data keeps changing
	always @(negedge tx_clk) begin
		tx_en <= go;
		tx_er <= go & er;
		txd <= go ? nib : ~txd;
	end
endmodule : phymii_mac_model
`default_nettype wire

// ==== tb/phymii_core_bench.sv ====
/*
 * self-checking bench for phymii_core with a MAC model on the pins.
 * assumes the package, design files, monitor and MAC model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module phymii_core_bench;
	import phymii_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic tx_clk_o, tx_clk_oe, tx_en, tx_er, rx_clk_o, rx_clk_oe, rx_oe;
	wire logic crs_o, col_o, crs_col_oe, interrupt_output, interrupt_output_oe;
	wire logic line_tx_valid, line_rx_ready;
	wire logic [3:0] txd;
	wire phymii_rx_t rx_o;
	wire phymii_cg_t line_tx;
	wire logic tx_pin = tx_clk_oe & tx_clk_o;
	logic [4:0] line_rx_code = 5'h00;
	logic line_rx_valid = 1'b0, line_rx_sfd = 1'b0, line_rx_err = 1'b0;
	logic line_rx_active = 1'b0, line_collision = 1'b0, line_sqe = 1'b0;
	logic line_link_change = 1'b0, mgo = 1'b0, mer = 1'b0;
	logic [3:0] mnib = 4'h0;
	logic [1:0] rsp;
	logic [31:0] rv;
	int n_errors = 0, check_count = 0, cyc = 0;

	phymii_core i_phymii_core (.ref_clk, .rst_n, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.tx_clk_o, .tx_clk_oe, .tx_en, .txd, .tx_er, .rx_clk_o, .rx_clk_oe, .rx_o, .rx_oe,
		.crs_o, .col_o, .crs_col_oe, .interrupt_output, .interrupt_output_oe, .line_tx,
		.line_tx_valid, .line_rx_valid, .line_rx_code, .line_rx_sfd, .line_rx_err,
		.line_rx_ready, .line_rx_active, .line_collision, .line_sqe, .line_link_change);
	phymii_mac_model i_phymii_mac_model (.tx_clk(tx_pin), .go(mgo), .er(mer), .nib(mnib),
		.tx_en, .tx_er, .txd);

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report;
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic da = 1'b0;
		logic dw = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge ref_clk);
			da = da | (s_axi_awvalid & s_axi_awready);
			dw = dw | (s_axi_wvalid & s_axi_wready);
			@(posedge ref_clk);
			if (da) s_axi_awvalid <= 1'b0;
			if (dw) s_axi_wvalid <= 1'b0;
		end while (!(da && dw));
		do @(negedge ref_clk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic da = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			da = s_axi_arready;
			@(posedge ref_clk);
			if (da) s_axi_arvalid <= 1'b0;
		end while (!da);
		do @(negedge ref_clk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
		chk(32'(rsp), 32'(RESP_OKAY));
	endtask : rc
	task automatic wtx;
		repeat (3) do @(negedge ref_clk); while (!line_tx_valid);
	endtask : wtx
	task automatic rxn(input logic [4:0] c, input logic s, input logic [5:0] e);
		line_rx_code <= c;
		line_rx_sfd <= s;
		line_rx_valid <= 1'b1;
		repeat (2) do @(negedge ref_clk); while (!line_rx_ready);
		@(negedge ref_clk);
		chk(32'(rx_o), 32'(e));
	endtask : rxn

	task automatic t_regs;
		tick(8);
		rc(ADDR_CONTROL, 32'(CONTROL_RST));
		rc(ADDR_VENDOR, 32'(VENDOR_RST));
		rc(ADDR_INT_CTRL, 32'(INT_CTRL_RST));
		rc(ADDR_MII_MODE, 32'(MODE_RST));
		rd(8'h08);
		chk({rv[29:0], rsp}, 32'(RESP_SLVERR));
		wr(8'h08, 32'hFFFF);
		chk(32'(rsp), 32'(RESP_SLVERR));
	endtask : t_regs
	task automatic t_tx;
		wr(ADDR_CONTROL, 32'h0);
		mnib <= 4'hA;
		mer <= 1'b1;
		mgo <= 1'b1;
		wtx();
		chk(32'(line_tx), 32'h0A);
		chk(32'(crs_o), 32'h1);
		wr(ADDR_CONTROL, 32'h2000);
		wtx();
		chk(32'(line_tx), 32'({1'b1, ERR_CODE}));
		wr(ADDR_MII_MODE, 32'h2);
		wtx();
		chk(32'(line_tx.code), 32'h1A);
		mgo <= 1'b0;
		mer <= 1'b0;
		wr(ADDR_MII_MODE, 32'h0);
		tick(12);
		chk(32'(crs_o), 32'h0);
	endtask : t_tx
	task automatic t_rx;
		line_rx_active <= 1'b1;
		rxn(5'h13, 1'b0, 6'h13);
		line_rx_err <= 1'b1;
		rxn(5'h03, 1'b0, 6'h33);
		wr(ADDR_MII_MODE, 32'h2);
		rxn(5'h03, 1'b0, 6'h13);
		line_rx_err <= 1'b0;
		wr(ADDR_MII_MODE, 32'h0);
		wr(ADDR_CONTROL, 32'h0);
		rxn(5'h05, 1'b0, 6'h05);
		rxn(5'h0D, 1'b1, 6'h1D);
		line_rx_valid <= 1'b0;
		line_rx_active <= 1'b0;
		tick(20);
		chk(32'(rx_o), 32'h0);
		wr(ADDR_CONTROL, 32'h2000);
		wr(ADDR_VENDOR, 32'h1);
		tick(4);
		rv = 32'h0;
		repeat (20) @(negedge ref_clk) rv = rv | 32'(rx_clk_o);
		chk(rv, 32'h0);
		wr(ADDR_VENDOR, 32'h0);
	endtask : t_rx
	task automatic t_iso;
		wr(ADDR_CONTROL, 32'h2400);
		chk(32'({tx_clk_oe, rx_oe, rx_clk_oe, crs_col_oe}), 32'h0);
		wr(ADDR_CONTROL, 32'h2000);
		wr(ADDR_MII_MODE, 32'h1);
		chk(32'({tx_clk_oe, rx_oe}), 32'h1);
		wr(ADDR_MII_MODE, 32'h0);
	endtask : t_iso
	task automatic t_int;
		rd(ADDR_INT_CTRL);
		wr(ADDR_VENDOR, 32'h4000);
		wr(ADDR_INT_CTRL, 32'h8000);
		line_link_change <= 1'b1;
		tick(1);
		line_link_change <= 1'b0;
		tick(3);
		chk(32'({interrupt_output_oe, interrupt_output}), 32'h3);
		rc(ADDR_INT_CTRL, 32'h8080);
		chk(32'(interrupt_output_oe), 32'h0);
		wr(ADDR_INT_CTRL, 32'h0);
		line_link_change <= 1'b1;
		tick(1);
		line_link_change <= 1'b0;
		tick(3);
		chk(32'(interrupt_output_oe), 32'h0);
	endtask : t_int
	task automatic t_rep;
		wr(ADDR_CONTROL, 32'h0100);
		wr(ADDR_VENDOR, 32'h8000);
		rc(ADDR_CONTROL, 32'h0);
		mgo <= 1'b1;
		line_sqe <= 1'b1;
		tick(20);
		chk(32'({crs_o, col_o}), 32'h0);
		wr(ADDR_VENDOR, 32'h0);
		tick(3);
		chk(32'({crs_o, col_o}), 32'h3);
		mgo <= 1'b0;
		line_sqe <= 1'b0;
		line_collision <= 1'b1;
		tick(8);
		line_collision <= 1'b0;
	endtask : t_rep
	task automatic t_soft;
		wr(ADDR_VENDOR, 32'h4001);
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		tick(8);
		rc(ADDR_VENDOR, 32'h0);
		wr(ADDR_VENDOR, 32'h4001);
		wr(ADDR_CONTROL, 32'h8000);
		tick(8);
		rc(ADDR_VENDOR, 32'h0);
		rc(ADDR_CONTROL, 32'(CONTROL_RST));
	endtask : t_soft

	initial begin
		tick(10);
		rst_n <= 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_iso();
		t_int();
		t_rep();
		t_soft();
		final_report();
	end
endmodule : phymii_core_bench
`default_nettype wire
